// ===== inc/bridge_reset_defines.svh
`ifndef BRIDGE_RESET_DEFINES_SVH
`define BRIDGE_RESET_DEFINES_SVH

// ==========================================
// clock and timing
`define CLK_MHZ              100
`define POR_DELAY_US         10
`define POR_DELAY_CYC        (`POR_DELAY_US * `CLK_MHZ)
`define TRAIN_LIMIT_MS       80
`define TRAIN_LIMIT_CYC      (`TRAIN_LIMIT_MS * 1000 * `CLK_MHZ)
`define PERST_PWR_MS         100
`define PERST_PWR_CYC        (`PERST_PWR_MS * 1000 * `CLK_MHZ)
`define PERST_CLK_US         100
`define PERST_CLK_CYC        (`PERST_CLK_US * `CLK_MHZ)
`define HOT_RESET_CYC        16

// ==========================================
// device configuration registers
`define SEC_BUS_CTL_OFS      8'h3E
`define SEC_BUS_CTL_RST      16'h0000
`define SEC_BUS_RST_BIT      6
`define DEV_STATUS_OFS       8'h40
`define STRAP_OFS            8'h42
`define STICKY_SCRATCH_OFS   8'h44
`define STICKY_SCRATCH_RST   16'h0000

// ==========================================
// controller registers
`define HC_CTRL_OFS          3'h0
`define HC_STATUS_OFS        3'h1
`define HC_CFG_ADDR_OFS      3'h2
`define HC_CFG_WDATA_OFS     3'h3
`define HC_CFG_RDATA_OFS     3'h4
`define HC_CTRL_UP_BIT       0
`define HC_CTRL_DOWN_BIT     1
`define HC_CTRL_HOT_BIT      2
`define HC_CTRL_CFGRD_BIT    3

`endif

// ===== inc/bridge_reset_pkg.sv
package bridge_reset_pkg;

   typedef logic [15:0] word_t;
   typedef logic [7:0]  cfg_addr_t;

   typedef enum logic [3:0] {
      POR_SUPPLY = 4'b0001,
      POR_CLOCK  = 4'b0010,
      POR_DELAY  = 4'b0100,
      POR_DONE   = 4'b1000
   } por_state_e;

   typedef enum logic [3:0] {
      LK_IDLE   = 4'b0001,
      LK_EEPROM = 4'b0010,
      LK_TRAIN  = 4'b0100,
      LK_DOWN   = 4'b1000
   } link_state_e;

   typedef enum logic [5:0] {
      H_OFF    = 6'b000001,
      H_SUPPLY = 6'b000010,
      H_CLOCK  = 6'b000100,
      H_ON     = 6'b001000,
      H_DNCLK  = 6'b010000,
      H_DNPWR  = 6'b100000
   } host_state_e;

endpackage

// ===== inc/bridge_reset_if.sv
interface bridge_reset_if;
   import bridge_reset_pkg::*;

   logic      perstN;
   logic      coreSupplySense;
   logic      refclkStable;
   logic      hotReset;
   cfg_addr_t cfgAddr;
   word_t     cfgWdata;
   logic      cfgWr;
   logic      cfgRd;
   word_t     cfgRdata;
   logic      linkUp;

   modport device (
      input  perstN,
      input  coreSupplySense,
      input  refclkStable,
      input  hotReset,
      input  cfgAddr,
      input  cfgWdata,
      input  cfgWr,
      input  cfgRd,
      output cfgRdata,
      output linkUp
   );

   modport host (
      output perstN,
      output coreSupplySense,
      output refclkStable,
      output hotReset,
      output cfgAddr,
      output cfgWdata,
      output cfgWr,
      output cfgRd,
      input  cfgRdata,
      input  linkUp
   );

endinterface

// ===== hdl/reset_release_sync.sv
module reset_release_sync (
   // clock
   input  wire logic clock,
   // asynchronous reset request, active low
   input  wire logic asyncRstN,
   // synchronised release
   output logic      syncRstN
);

   logic stage1Reg;
   logic stage2Reg;

   // assert at once, release only after two clean edges
   always_ff @(posedge clock or negedge asyncRstN)
   begin
      if (!asyncRstN)
      begin
         stage1Reg <= 1'b0;
         stage2Reg <= 1'b0;
      end
      else
      begin
         stage1Reg <= 1'b1;
         stage2Reg <= stage1Reg; // [R16]
      end
   end

   assign syncRstN = stage2Reg;

endmodule

// ===== hdl/bridge_reset_device.sv
// Function
// R01: system asserts PERST, powers up, then clocks
// R02: PERST held 100 us after stable clock
// R03: PERST held 100 ms after power
// R04: power-down: PERST, stop clock, remove power
// R05: PERST before power or clock loss
// R06: POR held until supply, clock, 10 us
// R07: POR resets everything, asserts PCI bus reset
// R08: global reset low acts as async POR
// R09: global reset release latches straps, starts link
// R10: PERST low resets non-sticky state, bus reset
// R11: PERST rising edge means power good
// R12: PERST release latches straps, starts link
// R13: hot reset moves link into DL_DOWN
// R14: DL_DOWN resets all but sticky/EEPROM/aux; code resets only config regs and bus reset
// R15: bus reset bit 6 at 3Eh drives bus reset
// R16: async reset release synchronised to clock
//
// Local design decision: the plain strobed port.
`include "bridge_reset_defines.svh"

module bridge_reset_device
   import bridge_reset_pkg::*;
#(
   parameter int unsigned TRAIN_LIMIT = `TRAIN_LIMIT_CYC
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // link to the upstream party
   bridge_reset_if.device  link,
   // board-level inputs
   input  wire logic       global_reset_in_n,
   input  wire logic [7:0] strapIn,
   input  wire logic       eepromPresent,
   input  wire logic       eepromDone,
   // reset scopes
   output logic            porActive,
   output logic            fullReset,
   output logic            nonStickyReset,
   output logic            configReset,
   output logic            pciBusReset,
   // sequencing
   output logic [7:0]      strapLatched,
   output logic            eepromStart,
   output logic            trainStart,
   output logic            dlDown
);

   localparam logic [9:0]  POR_LAST   = 10'(`POR_DELAY_CYC - 1);
   localparam logic [22:0] TRAIN_LAST = 23'(TRAIN_LIMIT - 1);

   por_state_e  porState_reg;
   por_state_e  porState_next;
   link_state_e linkState_reg;
   link_state_e linkState_next;
   logic [9:0]  porCnt_reg;
   logic [22:0] trainCnt_reg;
   logic        nsRstPrev_reg;
   logic        grstRelN;
   word_t       secBusCtl_reg;
   word_t       scratch_reg;
   word_t       rdata_reg;
   logic        linkUp_reg;

   // ==========================================
   // global reset release
   reset_release_sync grstSync (
      .clock     (clock),
      .asyncRstN (global_reset_in_n),
      .syncRstN  (grstRelN)
   );

   // ==========================================
   // power-on reset
   wire porHold = (porState_reg != POR_DONE);
   wire porDone = (porCnt_reg == POR_LAST);

   always_comb
   begin
      porState_next = porState_reg;
      unique case (porState_reg)
         POR_SUPPLY:
            if (link.coreSupplySense)
               porState_next = POR_CLOCK;
         POR_CLOCK:
            if (link.refclkStable)
               porState_next = POR_DELAY;
         POR_DELAY:
            if (!link.refclkStable)
               porState_next = POR_CLOCK;
            else if (porDone)
               porState_next = POR_DONE; // [R06]
         POR_DONE:
            porState_next = POR_DONE;
      endcase
      if (!link.coreSupplySense)
         porState_next = POR_SUPPLY; // [R06]
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         porState_reg <= POR_SUPPLY;
         porCnt_reg   <= '0;
      end
      else
      begin
         porState_reg <= porState_next;
         porCnt_reg   <= (porState_reg == POR_DELAY) ? porCnt_reg + 10'h001 : 10'h000;
      end
   end

   // ==========================================
   // reset scopes
   wire fullRst  = porHold | !grstRelN;               // [R07] [R08]
   wire perstLow = !link.perstN;
   wire nsRst    = fullRst | perstLow;                // [R10]
   wire inDown   = (linkState_reg == LK_DOWN);
   wire cfgRst   = nsRst | inDown;                    // [R14]
   wire cfgWrOk  = link.cfgWr & !cfgRst;              // [R14]
   wire cfgRdOk  = link.cfgRd & !cfgRst;
   wire startEv  = nsRstPrev_reg & !nsRst;            // [R09] [R11] [R12]
   wire busRst   = nsRst | inDown | secBusCtl_reg[`SEC_BUS_RST_BIT]; // [R15]

   // assert immediately on the pin, release on the clock
   always_ff @(posedge clock or negedge global_reset_in_n)
   begin
      if (!global_reset_in_n)
      begin
         porActive      <= 1'b1;
         fullReset      <= 1'b1;
         nonStickyReset <= 1'b1;
         configReset    <= 1'b1;
         pciBusReset    <= 1'b1; // [R08]
      end
      else if (!reset_n)
      begin
         porActive      <= 1'b1;
         fullReset      <= 1'b1;
         nonStickyReset <= 1'b1;
         configReset    <= 1'b1;
         pciBusReset    <= 1'b1;
      end
      else
      begin
         porActive      <= porHold;
         fullReset      <= fullRst;
         nonStickyReset <= nsRst;
         configReset    <= cfgRst;
         pciBusReset    <= busRst; // [R07] [R10] [R15]
      end
   end

   // ==========================================
   // link bring-up
   wire trainDue = eepromDone | (trainCnt_reg == TRAIN_LAST);

   always_comb
   begin
      linkState_next = linkState_reg;
      unique case (linkState_reg)
         LK_IDLE:
            if (startEv)
               linkState_next = eepromPresent ? LK_EEPROM : LK_TRAIN;
         LK_EEPROM:
            if (trainDue)
               linkState_next = LK_TRAIN; // [R09] [R12]
         LK_TRAIN:
            if (link.hotReset)
               linkState_next = LK_DOWN; // [R13]
         LK_DOWN:
            if (!link.hotReset)
               linkState_next = LK_TRAIN;
      endcase
   end

   wire trainGo = (linkState_next == LK_TRAIN) && (linkState_reg != LK_TRAIN);

   // bring-up state survives DL_DOWN, cleared by any non-sticky reset
   always_ff @(posedge clock)
   begin
      if (!reset_n || nsRst)
      begin
         linkState_reg <= LK_IDLE;
         trainCnt_reg  <= '0;
         eepromStart   <= 1'b0;
         trainStart    <= 1'b0;
         dlDown        <= 1'b0;
         linkUp_reg    <= 1'b0;
      end
      else
      begin
         linkState_reg <= linkState_next;
         trainCnt_reg  <= (linkState_reg == LK_EEPROM) ? trainCnt_reg + 23'h000001 : 23'h000000;
         eepromStart   <= startEv & eepromPresent; // [R09] [R12]
         trainStart    <= trainGo;
         dlDown        <= (linkState_next == LK_DOWN); // [R13]
         linkUp_reg    <= (linkState_next == LK_TRAIN);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         nsRstPrev_reg <= 1'b1;
      else
         nsRstPrev_reg <= nsRst;
   end

   // straps and scratch are kept through PERST and DL_DOWN
   always_ff @(posedge clock)
   begin
      if (!reset_n || fullRst)
      begin
         strapLatched <= 8'h00;
         scratch_reg  <= `STICKY_SCRATCH_RST;
      end
      else
      begin
         if (startEv)
            strapLatched <= strapIn; // [R09] [R12]
         if (cfgWrOk && link.cfgAddr == `STICKY_SCRATCH_OFS)
            scratch_reg <= link.cfgWdata;
      end
   end

   // ==========================================
   // configuration access
   word_t statusWord;
   word_t rdMux;

   assign statusWord = {10'h000, !grstRelN, perstLow, linkUp_reg, inDown,
                        (linkState_reg == LK_EEPROM), porHold};
   assign rdMux = (link.cfgAddr == `SEC_BUS_CTL_OFS)    ? secBusCtl_reg :
                  (link.cfgAddr == `DEV_STATUS_OFS)     ? statusWord    :
                  (link.cfgAddr == `STRAP_OFS)          ? {8'h00, strapLatched} :
                  (link.cfgAddr == `STICKY_SCRATCH_OFS) ? scratch_reg   :
                                                          16'h0000;

   always_ff @(posedge clock)
   begin
      if (!reset_n || cfgRst)
         secBusCtl_reg <= `SEC_BUS_CTL_RST; // [R14]
      else if (cfgWrOk && link.cfgAddr == `SEC_BUS_CTL_OFS)
         secBusCtl_reg <= link.cfgWdata; // [R15]
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         rdata_reg <= 16'h0000;
      else
         rdata_reg <= cfgRdOk ? rdMux : 16'h0000;
   end

   assign link.cfgRdata = rdata_reg;
   assign link.linkUp   = linkUp_reg;

endmodule

// ===== hdl/bridge_reset_host.sv
`include "bridge_reset_defines.svh"

module bridge_reset_host
   import bridge_reset_pkg::*;
#(
   parameter int unsigned PWR_WAIT = `PERST_PWR_CYC,
   parameter int unsigned CLK_WAIT = `PERST_CLK_CYC
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // link to the bridge
   bridge_reset_if.host    link,
   // register port
   input  wire logic [2:0] regAddr,
   input  wire word_t      regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output word_t           regRdata
);

   localparam logic [23:0] PWR_LAST = 24'(PWR_WAIT - 1);
   localparam logic [23:0] CLK_LAST = 24'(CLK_WAIT - 1);
   localparam logic [4:0]  HOT_LEN  = 5'(`HOT_RESET_CYC);

   host_state_e state_reg;
   host_state_e state_next;
   logic [23:0] pwrCnt_reg;
   logic [23:0] clkCnt_reg;
   logic [4:0]  hotCnt_reg;
   logic        perstN_reg;
   logic        supply_reg;
   logic        refclk_reg;
   logic        hot_reg;
   cfg_addr_t   cfgAddr_reg;
   word_t       cfgWdata_reg;
   logic        cfgWr_reg;
   logic        cfgRd_reg;
   logic        cfgRdPend_reg;
   word_t       cfgRdata_reg;

   // ==========================================
   // register decode
   wire ctrlWr  = regWr && regAddr == `HC_CTRL_OFS;
   wire upReq   = ctrlWr && regWdata[`HC_CTRL_UP_BIT];
   wire downReq = ctrlWr && regWdata[`HC_CTRL_DOWN_BIT];
   wire inOn    = (state_reg == H_ON);
   wire hotReq  = ctrlWr && regWdata[`HC_CTRL_HOT_BIT] && inOn;
   wire rdReq   = ctrlWr && regWdata[`HC_CTRL_CFGRD_BIT] && inOn;
   wire wrReq   = regWr && regAddr == `HC_CFG_WDATA_OFS && inOn;
   wire waitMet = (pwrCnt_reg >= PWR_LAST) && (clkCnt_reg >= CLK_LAST); // [R02] [R03]

   // ==========================================
   // supply, clock and PERST sequence
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         H_OFF:
            if (upReq)
               state_next = H_SUPPLY; // [R01]
         H_SUPPLY:
            state_next = downReq ? H_DNPWR : H_CLOCK;
         H_CLOCK:
            if (downReq)
               state_next = H_DNCLK;
            else if (waitMet)
               state_next = H_ON;
         H_ON:
            if (downReq)
               state_next = H_DNCLK; // [R04] [R05]
         H_DNCLK:
            state_next = H_DNPWR;
         H_DNPWR:
            state_next = H_OFF;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         state_reg  <= H_OFF;
         perstN_reg <= 1'b0;
         supply_reg <= 1'b0;
         refclk_reg <= 1'b0;
         pwrCnt_reg <= '0;
         clkCnt_reg <= '0;
      end
      else
      begin
         state_reg  <= state_next;
         perstN_reg <= (state_next == H_ON); // [R01] [R05]
         supply_reg <= (state_next != H_OFF); // [R04]
         refclk_reg <= state_next inside {H_CLOCK, H_ON, H_DNCLK}; // [R04] [R05]
         pwrCnt_reg <= (supply_reg && !waitMet) ? pwrCnt_reg + 24'h000001 :
                       (supply_reg ? pwrCnt_reg : 24'h000000);
         clkCnt_reg <= (state_reg == H_CLOCK && clkCnt_reg < CLK_LAST) ?
                       clkCnt_reg + 24'h000001 :
                       ((state_reg == H_CLOCK) ? clkCnt_reg : 24'h000000); // [R02]
      end
   end

   // ==========================================
   // hot reset and configuration forwarding
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         hotCnt_reg   <= '0;
         hot_reg      <= 1'b0;
         cfgAddr_reg  <= 8'h00;
         cfgWdata_reg <= 16'h0000;
         cfgWr_reg    <= 1'b0;
         cfgRd_reg    <= 1'b0;
         cfgRdPend_reg <= 1'b0;
         cfgRdata_reg <= 16'h0000;
         regRdata     <= 16'h0000;
      end
      else
      begin
         hotCnt_reg <= hotReq ? HOT_LEN :
                       ((hotCnt_reg != 5'h00 && inOn) ? hotCnt_reg - 5'h01 : 5'h00);
         hot_reg    <= hotReq | (hotCnt_reg > 5'h01 && inOn);
         if (regWr && regAddr == `HC_CFG_ADDR_OFS)
            cfgAddr_reg <= regWdata[7:0];
         if (regWr && regAddr == `HC_CFG_WDATA_OFS)
            cfgWdata_reg <= regWdata;
         cfgWr_reg <= wrReq;
         cfgRd_reg <= rdReq;
         // read data stands one cycle after the strobe
         cfgRdPend_reg <= cfgRd_reg;
         if (cfgRdPend_reg)
            cfgRdata_reg <= link.cfgRdata;
         unique case (1'b1)
            regRd && regAddr == `HC_STATUS_OFS:
               regRdata <= {8'h00, hot_reg, link.linkUp, state_reg};
            regRd && regAddr == `HC_CFG_ADDR_OFS:
               regRdata <= {8'h00, cfgAddr_reg};
            regRd && regAddr == `HC_CFG_WDATA_OFS:
               regRdata <= cfgWdata_reg;
            regRd && regAddr == `HC_CFG_RDATA_OFS:
               regRdata <= cfgRdata_reg;
            default:
               regRdata <= 16'h0000;
         endcase
      end
   end

   assign link.perstN          = perstN_reg;
   assign link.coreSupplySense = supply_reg;
   assign link.refclkStable    = refclk_reg;
   assign link.hotReset        = hot_reg;
   assign link.cfgAddr         = cfgAddr_reg;
   assign link.cfgWdata        = cfgWdata_reg;
   assign link.cfgWr           = cfgWr_reg;
   assign link.cfgRd           = cfgRd_reg;

endmodule

// ===== verification/bridge_reset_chk.sv
module bridge_reset_chk
   import bridge_reset_pkg::*;
#(
   parameter int unsigned PWR_WAIT = 40,
   parameter int unsigned CLK_WAIT = 20
) (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  reset_n,
   // link signals
   input  wire logic  perstN,
   input  wire logic  coreSupplySense,
   input  wire logic  refclkStable,
   input  wire logic  hotReset,
   input  wire logic  cfgRd,
   input  wire word_t cfgRdata,
   input  wire logic  linkUp
);
   int unsigned pwrCnt;
   int unsigned clkCnt;

   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // ==========================================
   // time spent with supply and clock up
   always_ff @(posedge clock)
   begin
      pwrCnt <= (!reset_n || !coreSupplySense) ? 0 : pwrCnt + 1;
      clkCnt <= (!reset_n || !refclkStable) ? 0 : clkCnt + 1;
   end

   // ==========================================
   // properties
   perst_order_a: assert property ($rose(perstN) |-> coreSupplySense && refclkStable)
      else $error("reset released before supply and clock");
   perst_clk_a: assert property ($rose(perstN) |-> clkCnt + 2 >= CLK_WAIT)
      else $error("reset released too soon after clock");
   perst_pwr_a: assert property ($rose(perstN) |-> pwrCnt + 2 >= PWR_WAIT)
      else $error("reset released too soon after power");
   down_order_a: assert property ($fell(coreSupplySense) |-> !refclkStable && !$past(refclkStable))
      else $error("supply removed while clock runs");
   perst_first_a: assert property (($fell(refclkStable) || $fell(coreSupplySense)) |-> !perstN && !$past(perstN))
      else $error("power or clock lost while reset released");
   link_perst_a: assert property (!perstN [*3] |-> !linkUp)
      else $error("link up while reset held");
   link_power_a: assert property ($rose(linkUp) |-> perstN && $past(perstN))
      else $error("link up without power good");
   hot_down_a: assert property ($rose(hotReset) && linkUp |-> ##[1:3] !linkUp)
      else $error("hot reset did not take link down");
   rdata_gap_a: assert property (cfgRdata != 16'h0000 |-> $past(cfgRd))
      else $error("read data without read strobe");
endmodule

// ===== verification/bridge_reset_sequencer_test.sv
`include "bridge_reset_defines.svh"

module bridge_reset_sequencer_test
   import bridge_reset_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic       clock;
   logic       reset_n;
   logic       global_reset_in_n;
   logic [7:0] strapIn;
   logic       eepromPresent;
   logic       eepromDone;
   logic       porActive, fullReset, nonStickyReset, configReset, pciBusReset;
   logic       eepromStart, trainStart, dlDown;
   logic [7:0] strapLatched;
   logic [2:0] regAddr;
   word_t      regWdata, regRdata, rd;
   logic       regWr, regRd;
   int         n_errors = 0;
   int         comparisons = 0;
   int         nEep = 0;
   int         nTrain = 0;
   int         cnt;

   bridge_reset_if bif ();

   bridge_reset_device #(.TRAIN_LIMIT(50)) bridge_reset_device_i (
      .clock(clock), .reset_n(reset_n), .link(bif.device),
      .global_reset_in_n(global_reset_in_n), .strapIn(strapIn),
      .eepromPresent(eepromPresent), .eepromDone(eepromDone),
      .porActive(porActive), .fullReset(fullReset), .nonStickyReset(nonStickyReset),
      .configReset(configReset), .pciBusReset(pciBusReset), .strapLatched(strapLatched),
      .eepromStart(eepromStart), .trainStart(trainStart), .dlDown(dlDown));

   bridge_reset_host #(.PWR_WAIT(40), .CLK_WAIT(20)) bridge_reset_host_i (
      .clock(clock), .reset_n(reset_n), .link(bif.host), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

   bridge_reset_chk #(.PWR_WAIT(40), .CLK_WAIT(20)) bridge_reset_chk_i (
      .clock(clock), .reset_n(reset_n), .perstN(bif.perstN),
      .coreSupplySense(bif.coreSupplySense), .refclkStable(bif.refclkStable),
      .hotReset(bif.hotReset), .cfgRd(bif.cfgRd), .cfgRdata(bif.cfgRdata),
      .linkUp(bif.linkUp));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // pulse counters
   always @(posedge clock)
   begin
      nEep <= nEep + eepromStart;
      nTrain <= nTrain + trainStart;
   end

   // ==========================================
   // tasks
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic regWrite(input logic [2:0] a, input word_t d);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic regCheck(input logic [2:0] a, input word_t exp);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1;
      check(regRdata, exp);
   endtask

   task automatic cfgWrite(input logic [7:0] a, input word_t d);
      regWrite(`HC_CFG_ADDR_OFS, {8'h00, a});
      regWrite(`HC_CFG_WDATA_OFS, d);
      repeat (3) @(posedge clock);
      #1;
   endtask

   task automatic cfgCheck(input logic [7:0] a, input word_t exp);
      regWrite(`HC_CFG_ADDR_OFS, {8'h00, a});
      regWrite(`HC_CTRL_OFS, 16'h0008);
      repeat (3) @(posedge clock);
      regCheck(`HC_CFG_RDATA_OFS, exp);
   endtask

   task automatic waitVal(ref logic s, input logic v, input int lim);
      int i = 0;
      while (s !== v && i < lim)
      begin
         @(posedge clock);
         #1;
         i++;
      end
      check(s, v);
   endtask

   // ==========================================
   // watchdog
   initial
   begin
      #100000;
      n_errors++;
      print_verdict();
   end

   // ==========================================
   // main sequence
   initial
   begin
      reset_n = 1'b0;
      global_reset_in_n = 1'b1;
      strapIn = 8'hA5;
      eepromPresent = 1'b0;
      eepromDone = 1'b0;
      regAddr = 3'h0;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      #1;
      check(porActive, 1'b1);
      check(pciBusReset, 1'b1);
      regCheck(3'h7, 16'h0000);
      regCheck(`HC_STATUS_OFS, 16'h0001);
      // power up without EEPROM
      regWrite(`HC_CTRL_OFS, 16'h0001);
      waitVal(bif.refclkStable, 1'b1, 20);
      cnt = 0;
      while (porActive === 1'b1 && cnt < 1100)
      begin
         @(posedge clock);
         #1;
         cnt++;
      end
      check(cnt >= 998 && cnt <= 1006, 1'b1);
      waitVal(nonStickyReset, 1'b0, 5);
      check(strapLatched, 8'hA5);
      waitVal(bif.linkUp, 1'b1, 3);
      @(posedge clock);
      #1;
      check(nTrain, 1);
      check(pciBusReset, 1'b0);
      // secondary bus reset bit
      cfgWrite(8'h3E, 16'h0040);
      check(pciBusReset, 1'b1);
      cfgCheck(8'h3E, 16'h0040);
      cfgWrite(8'h3E, 16'h0000);
      check(pciBusReset, 1'b0);
      // hot reset spares sticky scratch
      cfgWrite(8'h44, 16'h1234);
      cfgWrite(8'h3E, 16'h0040);
      regWrite(`HC_CTRL_OFS, 16'h0004);
      waitVal(dlDown, 1'b1, 10);
      @(posedge clock);
      #1;
      check(configReset, 1'b1);
      check(nonStickyReset, 1'b0);
      regCheck(`HC_STATUS_OFS, 16'h0088);
      waitVal(bif.linkUp, 1'b1, 40);
      cfgCheck(8'h3E, 16'h0000);
      cfgCheck(8'h44, 16'h1234);
      check(pciBusReset, 1'b0);
      // power down
      regWrite(`HC_CTRL_OFS, 16'h0002);
      waitVal(bif.coreSupplySense, 1'b0, 10);
      repeat (2) @(posedge clock);
      #1;
      check(nonStickyReset, 1'b1);
      check(pciBusReset, 1'b1);
      check(porActive, 1'b1);
      // power up with EEPROM
      @(posedge clock);
      eepromPresent <= 1'b1;
      strapIn <= 8'h5A;
      regWrite(`HC_CTRL_OFS, 16'h0001);
      waitVal(nonStickyReset, 1'b0, 1200);
      @(posedge clock);
      #1;
      check(nEep, 1);
      check(strapLatched, 8'h5A);
      check(bif.linkUp, 1'b0);
      @(posedge clock);
      eepromDone <= 1'b1;
      waitVal(bif.linkUp, 1'b1, 5);
      cfgCheck(8'h42, 16'h005A);
      cfgCheck(8'h44, 16'h0000);
      // global reset, EEPROM never finishes
      cfgWrite(8'h44, 16'h1234);
      @(posedge clock);
      eepromDone <= 1'b0;
      strapIn <= 8'h3C;
      global_reset_in_n <= 1'b0;
      #1;
      check(fullReset, 1'b1);
      check(pciBusReset, 1'b1);
      repeat (3) @(posedge clock);
      global_reset_in_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check(fullReset, 1'b1);
      @(posedge clock);
      #1;
      check(fullReset, 1'b0);
      waitVal(bif.linkUp, 1'b1, 70);
      check(strapLatched, 8'h3C);
      cfgCheck(8'h44, 16'h0000);
      check(nEep, 2);
      check(nTrain, 4);
      print_verdict();
   end
endmodule
